// [shared/opt_pkg.sv]
// Purpose: shared constants and types for the output pulse timers
// Assumes: 40 MHz core clock, microsecond time bases
// Notes:   widths are fixed, no parameterisation
package opt_pkg;

	// ----------------------------------------
	// widths and counts
	// ----------------------------------------
	localparam int                NUM_TIMERS  = 4;
	localparam int                SEL_W       = 2;
	localparam int                CNT_W       = 12;
	localparam int                BASE_W      = 16;
	localparam int                ABS_W       = CNT_W + BASE_W;
	localparam logic [CNT_W-1:0]  CNT_ZERO    = 12'h000;
	localparam logic [CNT_W-1:0]  CNT_ONE     = 12'h001;
	localparam logic [CNT_W-1:0]  CNT_MAX     = 12'hFFF;
	localparam logic [CNT_W-1:0]  DELAY_MIN   = 12'h000;
	localparam logic [CNT_W-1:0]  DUR_MIN     = 12'h001;
	localparam logic [BASE_W-1:0] BASE_ZERO   = 16'h0000;
	localparam logic [BASE_W-1:0] BASE_ONE    = 16'h0001;
	localparam logic [BASE_W-1:0] BASE_RESET  = 16'h0001;
	localparam logic [CNT_W-1:0]  DELAY_RESET = 12'h000;
	localparam logic [CNT_W-1:0]  DUR_RESET   = 12'h001;

	// ----------------------------------------
	// timing: one microsecond tick from the core clock
	// ----------------------------------------
	localparam int               CLK_PERIOD_NS = 25;
	localparam int               TICK_NS       = 1000;
	localparam int               TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int               TICK_W        = 6;
	localparam logic [TICK_W-1:0] TICK_LAST    = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO    = 6'h00;
	localparam logic [TICK_W-1:0] TICK_ONE     = 6'h01;

	// ----------------------------------------
	// channel sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HIGH} chan_state_t;

endpackage

// [logic/pulse_channel.sv]
// Purpose: one timer channel, delay then high pulse on its line
// Assumes: us_tick is a one-cycle pulse every microsecond, bases never zero
// Notes:   a start while busy is ignored
module pulse_channel
	import opt_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              us_tick,
	input  wire logic              start,
	input  wire logic [CNT_W-1:0]  delay_count,
	input  wire logic [BASE_W-1:0] delay_base,
	input  wire logic [CNT_W-1:0]  dur_count,
	input  wire logic [BASE_W-1:0] dur_base,
	output logic                   pulse_out
);

	chan_state_t       state_q;
	chan_state_t       state_d;
	logic [BASE_W-1:0] us_q;
	logic [CNT_W-1:0]  left_q;
	logic              out_q;

	// ----------------------------------------
	// unit decode
	// ----------------------------------------
	// base is read live, so a base change also alters a running phase
	wire logic [BASE_W-1:0] base_now  = (state_q == ST_DELAY) ? delay_base : dur_base;
	wire logic              base_done = us_tick && (us_q == BASE_W'(base_now - BASE_ONE));
	wire logic              last_unit = base_done && (left_q == CNT_ONE);
	wire logic              zero_dly  = (delay_count == CNT_ZERO);

	// next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (start)
				begin
					state_d = zero_dly ? ST_HIGH : ST_DELAY;
				end
			end
			ST_DELAY:
			begin
				if (last_unit)
				begin
					state_d = ST_HIGH;
				end
			end
			ST_HIGH:
			begin
				if (last_unit)
				begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// state and output flop
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_IDLE;
			out_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			out_q   <= (state_d == ST_HIGH);
		end
	end

	// counters: preloaded while idle, so the start edge needs no load path
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			us_q   <= BASE_ZERO;
			left_q <= CNT_ZERO;
		end
		else if (state_q == ST_IDLE)
		begin
			us_q   <= BASE_ZERO;
			left_q <= zero_dly ? dur_count : delay_count;
		end
		else if (base_done)
		begin
			us_q   <= BASE_ZERO;
			left_q <= last_unit ? dur_count : CNT_W'(left_q - CNT_ONE);
		end
		else if (us_tick)
		begin
			us_q <= BASE_W'(us_q + BASE_ONE);
		end
	end

	assign pulse_out = out_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_START_DELAY: assert property (
		(state_q == ST_IDLE && start && !zero_dly) |=> (state_q == ST_DELAY && !pulse_out))
		else $error("start with delay did not enter delay phase low");
	AST_ZERO_DELAY: assert property (
		(state_q == ST_IDLE && start && zero_dly) |=> pulse_out)
		else $error("zero delay start did not raise output at once");
	AST_OUT_STATE: assert property (
		pulse_out == (state_q == ST_HIGH))
		else $error("output level disagrees with phase");
	AST_HIGH_END: assert property (
		(state_q == ST_HIGH && last_unit) |=> (!pulse_out && state_q == ST_IDLE))
		else $error("output not low after duration ended");
	AST_UNIT_TICK: assert property (
		(state_q != ST_IDLE && !us_tick) |=> $stable(left_q))
		else $error("count moved without a microsecond tick");

endmodule

// [logic/output_pulse_timers.sv]
// Purpose: four exposure-started pulse timers with raw and absolute settings
// Assumes: all control inputs synchronous to core_clk, one write per cycle
// Notes:   count, absolute and line readbacks lag the register state by one cycle; base readbacks do not
//
// Function
// - delay tick period resets to 1 us, settable in 1 us steps, minimum 1.
// - one delay tick period serves all four timers.
// - absolute delay is written in microseconds for the selected timer.
// - absolute delay write stores the matching delay count for that timer.
// - unachievable absolute delay becomes the nearest achievable multiple.
// - direct delay count change updates the absolute delay readback.
// - high time equals duration count times duration tick period.
// - duration count accepts only 1 through 4095.
// - duration tick period resets to 1 us, settable in 1 us steps.
// - one duration tick period serves all four timers.
// - absolute duration is written in microseconds for the selected timer.
// - absolute duration write sets the matching duration count.
// - absolute duration reads as count times duration tick period.
// - direct duration count change shows at once in absolute duration.
// - line status reads high or low level of the chosen output line.
// - on start, count delay, drive high for duration, then low.
// - delay time equals delay count times delay tick period.
// - delay count accepts 0 through 4095.
// - timer n drives line n; exposure start triggers it.
module output_pulse_timers
	import opt_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              exposure_start,
	input  wire logic [SEL_W-1:0]  timer_sel,
	input  wire logic              delay_base_wr,
	input  wire logic [BASE_W-1:0] delay_base_data,
	input  wire logic              dur_base_wr,
	input  wire logic [BASE_W-1:0] dur_base_data,
	input  wire logic              delay_count_wr,
	input  wire logic [CNT_W-1:0]  delay_count_data,
	input  wire logic              delay_abs_wr,
	input  wire logic [ABS_W-1:0]  delay_abs_data,
	input  wire logic              dur_count_wr,
	input  wire logic [CNT_W-1:0]  dur_count_data,
	input  wire logic              dur_abs_wr,
	input  wire logic [ABS_W-1:0]  dur_abs_data,
	input  wire logic [SEL_W-1:0]  line_sel,
	output logic [BASE_W-1:0]      delay_base_rd,
	output logic [BASE_W-1:0]      dur_base_rd,
	output logic [CNT_W-1:0]       delay_count_rd,
	output logic [ABS_W-1:0]       delay_abs_rd,
	output logic [CNT_W-1:0]       dur_count_rd,
	output logic [ABS_W-1:0]       dur_abs_rd,
	output logic                   line_status,
	output logic [NUM_TIMERS-1:0]  timer_out
);

	// ----------------------------------------
	// arithmetic helpers
	// ----------------------------------------
	// count times base, always fits the absolute width
	function automatic logic [ABS_W-1:0] span(input logic [CNT_W-1:0] cnt,
	                                          input logic [BASE_W-1:0] base);
		span = ABS_W'({{BASE_W{1'b0}}, cnt} * {{CNT_W{1'b0}}, base});
	endfunction

	// nearest count for a time, clamped to the legal count range
	function automatic logic [CNT_W-1:0] abs_to_count(input logic [ABS_W-1:0] abs_us,
	                                                  input logic [BASE_W-1:0] base,
	                                                  input logic [CNT_W-1:0] floor_cnt);
		logic [ABS_W:0] num;
		logic [ABS_W:0] quo;
		num = {1'b0, abs_us} + {{(ABS_W-BASE_W+1){1'b0}}, (base >> 1)};
		quo = num / {{(ABS_W-BASE_W+1){1'b0}}, base};
		if (quo > {{(ABS_W-CNT_W+1){1'b0}}, CNT_MAX})
			abs_to_count = CNT_MAX;
		else if (quo[CNT_W-1:0] < floor_cnt)
			abs_to_count = floor_cnt;
		else
			abs_to_count = quo[CNT_W-1:0];
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [TICK_W-1:0] tick_q;
	logic [BASE_W-1:0] delay_base_q;
	logic [BASE_W-1:0] dur_base_q;
	logic [CNT_W-1:0]  delay_cnt_q [NUM_TIMERS];
	logic [CNT_W-1:0]  dur_cnt_q   [NUM_TIMERS];
	logic [CNT_W-1:0]  delay_count_q;
	logic [CNT_W-1:0]  dur_count_q;
	logic [ABS_W-1:0]  delay_abs_q;
	logic [ABS_W-1:0]  dur_abs_q;
	logic              line_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic              us_tick     = (tick_q == TICK_LAST);
	// a zero base would stretch every unit to 65536 us, so it is lifted to the minimum
	wire logic [BASE_W-1:0] dly_base_in = (delay_base_data == BASE_ZERO) ? BASE_ONE : delay_base_data;
	wire logic [BASE_W-1:0] dur_base_in = (dur_base_data == BASE_ZERO) ? BASE_ONE : dur_base_data;
	wire logic [CNT_W-1:0]  dly_abs_cnt = abs_to_count(delay_abs_data, delay_base_q, DELAY_MIN);
	wire logic [CNT_W-1:0]  dur_abs_cnt = abs_to_count(dur_abs_data, dur_base_q, DUR_MIN);
	wire logic              dur_raw_ok  = (dur_count_data >= DUR_MIN);

	// microsecond tick prescaler
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			tick_q <= TICK_ZERO;
		else
			tick_q <= us_tick ? TICK_ZERO : TICK_W'(tick_q + TICK_ONE);
	end

	// shared time bases
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			delay_base_q <= BASE_RESET;
			dur_base_q   <= BASE_RESET;
		end
		else
		begin
			if (delay_base_wr)
				delay_base_q <= dly_base_in;
			if (dur_base_wr)
				dur_base_q <= dur_base_in;
		end
	end

	// per-timer counts; a raw write wins over an absolute write in one cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				delay_cnt_q[i] <= DELAY_RESET;
				dur_cnt_q[i]   <= DUR_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				if (timer_sel == SEL_W'(i))
				begin
					if (delay_count_wr)
						delay_cnt_q[i] <= delay_count_data;
					else if (delay_abs_wr)
						delay_cnt_q[i] <= dly_abs_cnt;
					if (dur_count_wr && dur_raw_ok)
						dur_cnt_q[i] <= dur_count_data;
					else if (dur_abs_wr && !dur_count_wr)
						dur_cnt_q[i] <= dur_abs_cnt;
				end
			end
		end
	end

	// readbacks: absolute values are always recomputed from the counts
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			delay_count_q <= DELAY_RESET;
			dur_count_q   <= DUR_RESET;
			delay_abs_q   <= {ABS_W{1'b0}};
			dur_abs_q     <= {{(ABS_W-CNT_W){1'b0}}, DUR_RESET};
			line_q        <= 1'b0;
		end
		else
		begin
			delay_count_q <= delay_cnt_q[timer_sel];
			dur_count_q   <= dur_cnt_q[timer_sel];
			delay_abs_q   <= span(delay_cnt_q[timer_sel], delay_base_q);
			dur_abs_q     <= span(dur_cnt_q[timer_sel], dur_base_q);
			line_q        <= timer_out[line_sel];
		end
	end

	// ----------------------------------------
	// channels, timer n fixed to line n
	// ----------------------------------------
	for (genvar g = 0; g < NUM_TIMERS; g++)
	begin : g_chan
		pulse_channel u_chan (
			.core_clk    (core_clk),
			.rstn        (rstn),
			.us_tick     (us_tick),
			.start       (exposure_start),
			.delay_count (delay_cnt_q[g]),
			.delay_base  (delay_base_q),
			.dur_count   (dur_cnt_q[g]),
			.dur_base    (dur_base_q),
			.pulse_out   (timer_out[g])
		);
	end

	assign delay_base_rd  = delay_base_q;
	assign dur_base_rd    = dur_base_q;
	assign delay_count_rd = delay_count_q;
	assign dur_count_rd   = dur_count_q;
	assign delay_abs_rd   = delay_abs_q;
	assign dur_abs_rd     = dur_abs_q;
	assign line_status    = line_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_TICK_GAP: assert property (@(posedge core_clk) disable iff (!rstn)
		us_tick |=> !us_tick [*8])
		else $error("microsecond tick repeated too soon");
	AST_BASE_MIN: assert property (@(posedge core_clk) disable iff (!rstn)
		(delay_base_q != BASE_ZERO) && (dur_base_q != BASE_ZERO))
		else $error("time base fell below one microsecond");
	AST_DUR_RAW_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
		(dur_count_wr && dur_count_data == CNT_ZERO)
		|=> dur_cnt_q[$past(timer_sel)] == $past(dur_cnt_q[timer_sel]))
		else $error("zero duration count was accepted");
	AST_DELAY_ABS_RT: assert property (@(posedge core_clk) disable iff (!rstn)
		(delay_abs_wr && !delay_count_wr && !delay_base_wr
		 && delay_abs_data == span(dly_abs_cnt, delay_base_q))
		##1 (!delay_base_wr && !delay_count_wr && !delay_abs_wr
		     && timer_sel == $past(timer_sel))
		|=> delay_abs_rd == $past(delay_abs_data, 2))
		else $error("achievable absolute delay not read back");
	AST_DUR_ABS_RD: assert property (@(posedge core_clk) disable iff (!rstn)
		1'b1 |=> dur_abs_rd == span($past(dur_cnt_q[timer_sel]), $past(dur_base_q)))
		else $error("absolute duration readback not count times base");
	AST_LINE_STATUS: assert property (@(posedge core_clk) disable iff (!rstn)
		1'b1 |=> line_status == $past(timer_out[line_sel]))
		else $error("line status does not follow selected line");

endmodule

// [bench/testbench.sv]
// Purpose: self-checking bench for the four output pulse timers
// Assumes: 40 MHz core_clk, all inputs driven on the falling edge
// Notes:   rise edges get one tick of slack, widths two cycles unless delay is zero; the us tick runs free
module testbench
	import opt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  core_clk;
	logic                  rstn;
	logic                  exposure_start;
	logic [SEL_W-1:0]      timer_sel;
	logic [SEL_W-1:0]      line_sel;
	logic [5:0]            wr_v;
	logic [ABS_W-1:0]      d_v;
	logic                  delay_base_wr;
	logic                  dur_base_wr;
	logic                  delay_count_wr;
	logic                  delay_abs_wr;
	logic                  dur_count_wr;
	logic                  dur_abs_wr;
	logic [BASE_W-1:0]     delay_base_rd;
	logic [BASE_W-1:0]     dur_base_rd;
	logic [CNT_W-1:0]      delay_count_rd;
	logic [ABS_W-1:0]      delay_abs_rd;
	logic [CNT_W-1:0]      dur_count_rd;
	logic [ABS_W-1:0]      dur_abs_rd;
	logic                  line_status;
	logic [NUM_TIMERS-1:0] timer_out;
	logic [NUM_TIMERS-1:0] prev_out;
	logic [NUM_TIMERS-1:0] fell;
	logic [CNT_W-1:0]      dc[NUM_TIMERS];
	logic [CNT_W-1:0]      uc[NUM_TIMERS];
	logic [BASE_W-1:0]     db;
	logic [BASE_W-1:0]     ub;
	int                    bad_count;
	int                    n_checks;
	int                    cyc;
	int                    t0;
	int                    rise_at[NUM_TIMERS];
	int                    fall_at[NUM_TIMERS];

	// one strobe vector and one data word feed every write port
	assign {dur_abs_wr, dur_count_wr, delay_abs_wr, delay_count_wr, dur_base_wr,
		delay_base_wr} = wr_v;

	output_pulse_timers i_dut (
		.core_clk, .rstn, .exposure_start, .timer_sel,
		.delay_base_wr, .delay_base_data(d_v[BASE_W-1:0]),
		.dur_base_wr, .dur_base_data(d_v[BASE_W-1:0]),
		.delay_count_wr, .delay_count_data(d_v[CNT_W-1:0]),
		.delay_abs_wr, .delay_abs_data(d_v),
		.dur_count_wr, .dur_count_data(d_v[CNT_W-1:0]),
		.dur_abs_wr, .dur_abs_data(d_v), .line_sel,
		.delay_base_rd, .dur_base_rd, .delay_count_rd, .delay_abs_rd,
		.dur_count_rd, .dur_abs_rd, .line_status, .timer_out
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi)
		begin
			bad_count++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	// nearest count, half rounds up; clamped to the count range
	function automatic logic [CNT_W-1:0] a2c(input logic [ABS_W-1:0] a,
		input logic [BASE_W-1:0] b, input int mn);
		longint q;
		q = (longint'(a) + b / 2) / b;
		if (q > 4095)
			q = 4095;
		if (q < mn)
			q = mn;
		return CNT_W'(q);
	endfunction

	// one write strobe of kind k, then the bench model follows it
	task automatic wr(input int k, input logic [SEL_W-1:0] s, input logic [ABS_W-1:0] d);
		@(negedge core_clk);
		timer_sel = s;
		d_v = d;
		wr_v = 6'h01 << k;
		@(negedge core_clk);
		wr_v = 6'h00;
		case (k)
			0: db = (d[BASE_W-1:0] == 16'h0000) ? 16'h0001 : d[BASE_W-1:0];
			1: ub = (d[BASE_W-1:0] == 16'h0000) ? 16'h0001 : d[BASE_W-1:0];
			2: dc[s] = d[CNT_W-1:0];
			3: dc[s] = a2c(d, db, 0);
			4: uc[s] = (d[CNT_W-1:0] == 12'h000) ? uc[s] : d[CNT_W-1:0];
			default: uc[s] = a2c(d, ub, 1);
		endcase
	endtask

	task automatic rd_all();
		for (int t = 0; t < NUM_TIMERS; t++)
		begin
			timer_sel = SEL_W'(t);
			repeat (3) @(negedge core_clk);
			chk("delay_count_rd", 32'(dc[t]), delay_count_rd);
			chk("delay_abs_rd", 32'(dc[t]) * db, delay_abs_rd);
			chk("dur_count_rd", 32'(uc[t]), dur_count_rd);
			chk("dur_abs_rd", 32'(uc[t]) * ub, dur_abs_rd);
		end
		chk("delay_base_rd", 32'(db), delay_base_rd);
		chk("dur_base_rd", 32'(ub), dur_base_rd);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// line monitor: edge times and the registered line readback
	// ----------------------------------------
	always @(posedge core_clk)
		cyc <= cyc + 1;

	always @(negedge core_clk)
	begin
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (timer_out[i] === 1'b1 && prev_out[i] !== 1'b1)
				rise_at[i] = cyc;
			if (timer_out[i] === 1'b0 && prev_out[i] === 1'b1)
			begin
				fall_at[i] = cyc;
				fell[i] = 1'b1;
			end
		end
		// the select driven since the last negedge is the one the readback flop used
		if (rstn)
			chk("line_status", 32'(prev_out[line_sel]), line_status);
		prev_out = timer_out;
		line_sel = SEL_W'($urandom);
	end

	// a hang is cut short well past the expected run length of a few thousand cycles
	initial
	begin
		#500_000;
		bad_count++;
		$display("Error watchdog expected done seen hang");
		finish_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		cyc = 0;
		rstn = 1'b0;
		exposure_start = 1'b0;
		timer_sel = 2'h0;
		line_sel = 2'h0;
		prev_out = 4'h0;
		wr_v = 6'h00;
		d_v = 28'h0000000;
		db = 16'h0001;
		ub = 16'h0001;
		dc = '{default: 12'h000};
		uc = '{default: 12'h001};
		void'($urandom(32'hBFA2));
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		rd_all();
		$display("test reset values done");
		// corners: zero bases, zero duration, rounding and clamping
		wr(0, 0, 0);
		wr(1, 0, 0);
		wr(4, 2, 0);
		wr(2, 1, 4095);
		wr(0, 0, 50);
		wr(3, 3, 75);
		wr(1, 0, 28'h000FFFF);
		wr(5, 0, 28'hFFFFFFF);
		wr(5, 1, 0);
		rd_all();
		$display("test corners done");
		repeat (4)
		begin
			repeat (10)
				wr($urandom % 6, SEL_W'($urandom), ABS_W'($urandom));
			rd_all();
		end
		$display("test random writes done");
		// pulses: small shared bases, all four timers from one start
		repeat (3)
		begin
			wr(0, 0, 1 + $urandom % 3);
			wr(1, 0, 1 + $urandom % 3);
			for (int t = 0; t < NUM_TIMERS; t++)
			begin
				wr(2, SEL_W'(t), $urandom % 8);
				wr(4, SEL_W'(t), 1 + $urandom % 8);
			end
			@(negedge core_clk);
			exposure_start = 1'b1;
			fell = 4'h0;
			rise_at = '{default: -1};
			fall_at = '{default: -1};
			t0 = cyc + 1;
			@(negedge core_clk);
			exposure_start = 1'b0;
			for (int i = 0; i < 4000 && fell !== 4'hF; i++)
				@(negedge core_clk);
			for (int t = 0; t < NUM_TIMERS; t++)
			begin
				chk_rng("rise", rise_at[t] - t0, dc[t] * db * 40 - 40, dc[t] * db * 40 + 2);
				// zero delay rises at start, off the free tick, so its first unit may be short
				chk_rng("width", fall_at[t] - rise_at[t], uc[t] * ub * 40 - ((dc[t] == 12'h000) ? 40 : 2),
					uc[t] * ub * 40 + 2);
			end
		end
		$display("test pulses done");
		finish_test();
	end
endmodule
